// ==== hw/brk_pkg.sv ====
// Constants, field layouts and types shared by the hardware break comparator
// =====================================================================
package brk_pkg;

    // =================================================================
    // Sizes
    localparam int NCH    = 8;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int CHAN_W = 3;

    // =================================================================
    // Channel roles (zero based: index 0 is channel 1)
    localparam int CNT_CH     = 0;
    localparam int PAIR_CH    = 1;
    localparam int DATA_CHANS = 2;

    // =================================================================
    // Timing
    // Cycles after a restart during which matches are dropped
    localparam logic [1:0] RESUME_IGNORE_CYC = 2'h2;
    // Depth of the cross-domain synchronisers
    localparam int SYNC_DEPTH = 3;

    // =================================================================
    // Reset values
    localparam logic [NCH-1:0] HITS_RST = 8'h00;

    // =================================================================
    // Encodings
    typedef enum logic [1:0] {SZ_WORD, SZ_HIGH, SZ_LOW} dsize_t;
    typedef enum logic [1:0] {ACT_BREAK, ACT_CNT_1TO2, ACT_CNT_2TO1} action_t;

    // One channel setting as carried across the link
    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic              en;
        logic              fetch;
        logic              data_en;
        dsize_t            dsize;
        logic              dir_en;
        logic              dir_wr;
        action_t           action;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_t;

endpackage

// ==== hw/hardware_break_comparator.sv ====
// Eight-channel hardware break comparator with link-clock configuration port
`timescale 1ns/1ps
module hardware_break_comparator (
    // System clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_b_i,
    // Debug link clock domain: channel setting command
    input  wire logic                         link_clk_i,
    input  wire logic                         cmd_valid_i,
    output logic                              cmd_ready_o,
    input  wire logic [brk_pkg::CHAN_W-1:0]   cmd_chan_i,
    input  wire logic                         cmd_en_i,
    input  wire logic                         cmd_fetch_i,
    input  wire logic                         cmd_data_en_i,
    input  wire logic [1:0]                   cmd_dsize_i,
    input  wire logic                         cmd_dir_en_i,
    input  wire logic                         cmd_dir_wr_i,
    input  wire logic [1:0]                   cmd_action_i,
    input  wire logic [brk_pkg::ADDR_W-1:0]   cmd_addr_i,
    input  wire logic [brk_pkg::DATA_W-1:0]   cmd_data_i,
    // CPU bus watched each cycle
    input  wire logic                         bus_valid_i,
    input  wire logic [brk_pkg::ADDR_W-1:0]   bus_addr_i,
    input  wire logic [brk_pkg::DATA_W-1:0]   bus_data_i,
    input  wire logic                         bus_write_i,
    input  wire logic                         bus_fetch_i,
    // CPU state
    input  wire logic                         flash_busy_i,
    input  wire logic                         step_mode_i,
    input  wire logic                         resume_i,
    // Debugger halt and memory requests
    input  wire logic                         halt_req_i,
    input  wire logic                         mem_req_i,
    output logic                              cpu_halt_o,
    output logic                              mem_grant_o,
    // Break and counter triggers
    output logic                              break_o,
    output logic [brk_pkg::NCH-1:0]           hit_chans_o,
    output logic                              count_start_o,
    output logic                              count_stop_o
);

    // =================================================================
    // Link side: hold the command and toggle a request
    brk_pkg::cmd_t                     hold_q, hold_d;
    logic                              req_q, req_d;
    logic [brk_pkg::SYNC_DEPTH-1:0]    ack_sync_q;
    logic                              ack_q;

    // Link stays busy until the system side returns the toggle
    assign cmd_ready_o = (req_q == ack_sync_q[2]);

    // Next command capture; held stable while the crossing is open
    always_comb begin
        hold_d = hold_q;
        req_d  = req_q;
        if (cmd_valid_i && cmd_ready_o) begin
            hold_d.chan    = cmd_chan_i;
            hold_d.en      = cmd_en_i;
            hold_d.fetch   = cmd_fetch_i;
            hold_d.data_en = cmd_data_en_i;
            hold_d.dsize   = brk_pkg::dsize_t'(cmd_dsize_i);
            hold_d.dir_en  = cmd_dir_en_i;
            hold_d.dir_wr  = cmd_dir_wr_i;
            hold_d.action  = brk_pkg::action_t'(cmd_action_i);
            hold_d.addr    = cmd_addr_i;
            hold_d.data    = cmd_data_i;
            req_d          = ~req_q;
        end
    end

    // Link registers and acknowledge synchroniser
    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hold_q     <= '0;
            req_q      <= 1'b0;
            ack_sync_q <= '0;
        end else begin
            hold_q     <= hold_d;
            req_q      <= req_d;
            ack_sync_q <= {ack_sync_q[1:0], ack_q};
        end
    end

    // =================================================================
    // System side: request synchroniser and channel settings
    logic [brk_pkg::SYNC_DEPTH-1:0]    req_sync_q;
    logic                              cfg_evt;
    logic                              ack_d;
    logic [brk_pkg::NCH-1:0]           en_q, en_d;
    logic [brk_pkg::NCH-1:0]           fetch_q, fetch_d;
    logic [brk_pkg::NCH-1:0]           den_q, den_d;
    logic [brk_pkg::NCH-1:0]           dir_en_q, dir_en_d;
    logic [brk_pkg::NCH-1:0]           dir_wr_q, dir_wr_d;
    brk_pkg::dsize_t                   dsize_q [brk_pkg::NCH];
    brk_pkg::dsize_t                   dsize_d [brk_pkg::NCH];
    logic [brk_pkg::ADDR_W-1:0]        addr_q  [brk_pkg::NCH];
    logic [brk_pkg::ADDR_W-1:0]        addr_d  [brk_pkg::NCH];
    logic [brk_pkg::DATA_W-1:0]        data_q  [brk_pkg::NCH];
    logic [brk_pkg::DATA_W-1:0]        data_d  [brk_pkg::NCH];
    brk_pkg::action_t                  action_q, action_d;

    // Second and third stages agree on a toggle not yet acknowledged
    assign cfg_evt = (req_sync_q[2] == req_sync_q[1]) && (req_sync_q[2] != ack_q);
    assign ack_d   = ack_q ^ cfg_evt;

    // Write one channel; the hold word is stable until the ack returns
    always_comb begin
        en_d     = en_q;
        fetch_d  = fetch_q;
        den_d    = den_q;
        dir_en_d = dir_en_q;
        dir_wr_d = dir_wr_q;
        dsize_d  = dsize_q;
        addr_d   = addr_q;
        data_d   = data_q;
        action_d = action_q;
        if (cfg_evt) begin
            en_d[hold_q.chan]     = hold_q.en;
            fetch_d[hold_q.chan]  = hold_q.fetch;
            dir_en_d[hold_q.chan] = hold_q.dir_en;
            dir_wr_d[hold_q.chan] = hold_q.dir_wr;
            dsize_d[hold_q.chan]  = hold_q.dsize;
            data_d[hold_q.chan]   = hold_q.data;
            // Instruction breaks land on the even address
            addr_d[hold_q.chan]   = hold_q.fetch ? {hold_q.addr[brk_pkg::ADDR_W-1:1], 1'b0}
                                                 : hold_q.addr;
            // Upper channels cannot hold a data condition
            den_d[hold_q.chan]    = hold_q.data_en &&
                                    (int'(hold_q.chan) < brk_pkg::DATA_CHANS);
            // Counter option exists on channel 1 only
            if (int'(hold_q.chan) == brk_pkg::CNT_CH) begin
                action_d = hold_q.action;
            end
        end
    end

    // Setting registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_sync_q <= '0;
            ack_q      <= 1'b0;
            en_q       <= '0;
            fetch_q    <= '0;
            den_q      <= '0;
            dir_en_q   <= '0;
            dir_wr_q   <= '0;
            action_q   <= brk_pkg::ACT_BREAK;
            for (int i = 0; i < brk_pkg::NCH; i++) begin
                dsize_q[i] <= brk_pkg::SZ_WORD;
                addr_q[i]  <= '0;
                data_q[i]  <= '0;
            end
        end else begin
            req_sync_q <= {req_sync_q[1:0], req_q};
            ack_q      <= ack_d;
            en_q       <= en_d;
            fetch_q    <= fetch_d;
            den_q      <= den_d;
            dir_en_q   <= dir_en_d;
            dir_wr_q   <= dir_wr_d;
            action_q   <= action_d;
            dsize_q    <= dsize_d;
            addr_q     <= addr_d;
            data_q     <= data_d;
        end
    end

    // =================================================================
    // Per-channel comparators
    logic [brk_pkg::NCH-1:0] match;

    for (genvar c = 0; c < brk_pkg::NCH; c++) begin : g_chan
        logic addr_ok;
        logic data_ok;
        logic dir_ok;
        logic kind_ok;

        assign addr_ok = (bus_addr_i == addr_q[c]);
        assign dir_ok  = !dir_en_q[c] || (bus_write_i == dir_wr_q[c]);
        assign kind_ok = !fetch_q[c] || bus_fetch_i;

        // Byte lane select for the data condition
        always_comb begin
            unique case (dsize_q[c])
                brk_pkg::SZ_HIGH: data_ok = bus_data_i[15:8] == data_q[c][15:8];
                brk_pkg::SZ_LOW:  data_ok = bus_data_i[7:0] == data_q[c][7:0];
                default:          data_ok = bus_data_i == data_q[c];
            endcase
        end

        assign match[c] = bus_valid_i && en_q[c] && addr_ok && dir_ok && kind_ok &&
                          (!den_q[c] || data_ok);

        // Instruction channels never hold an odd address
        a_even_fetch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
            fetch_q[c] |-> !addr_q[c][0])
            else $error("instruction break channel holds odd address");
    end

    // =================================================================
    // Suppression: flash routine, stepping, restart window
    logic [1:0] ign_q, ign_d;
    logic       quiet;

    // Restart window counts down in system cycles
    always_comb begin
        ign_d = ign_q;
        if (resume_i) begin
            ign_d = brk_pkg::RESUME_IGNORE_CYC;
        end else if (ign_q != 2'h0) begin
            ign_d = ign_q - 2'h1;
        end
    end

    // Any of these holds every channel silent
    assign quiet = flash_busy_i || step_mode_i || resume_i || (ign_q != 2'h0);

    // Debugger cannot stop the CPU or reach memory mid flash routine
    assign cpu_halt_o  = halt_req_i && !flash_busy_i;
    assign mem_grant_o = mem_req_i && !flash_busy_i;

    // =================================================================
    // Break and counter trigger outputs
    logic                    brk_q, brk_d;
    logic                    start_q, start_d;
    logic                    stop_q, stop_d;
    logic [brk_pkg::NCH-1:0] hits_q, hits_d;
    logic [brk_pkg::NCH-1:0] brk_hits;

    // In a counter mode, channels 1 and 2 trigger instead of breaking
    always_comb begin
        brk_hits = match;
        start_d  = 1'b0;
        stop_d   = 1'b0;
        unique case (action_q)
            brk_pkg::ACT_CNT_1TO2: begin
                start_d  = match[brk_pkg::CNT_CH] && !quiet;
                stop_d   = match[brk_pkg::PAIR_CH] && !quiet;
                brk_hits[brk_pkg::CNT_CH]  = 1'b0;
                brk_hits[brk_pkg::PAIR_CH] = 1'b0;
            end
            brk_pkg::ACT_CNT_2TO1: begin
                start_d  = match[brk_pkg::PAIR_CH] && !quiet;
                stop_d   = match[brk_pkg::CNT_CH] && !quiet;
                brk_hits[brk_pkg::CNT_CH]  = 1'b0;
                brk_hits[brk_pkg::PAIR_CH] = 1'b0;
            end
            default: begin
            end
        endcase
        // One request however many channels hit; record kept until next
        brk_d  = !quiet && (|brk_hits);
        hits_d = brk_d ? brk_hits : hits_q;
    end

    // Output registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ign_q   <= 2'h0;
            brk_q   <= 1'b0;
            start_q <= 1'b0;
            stop_q  <= 1'b0;
            hits_q  <= brk_pkg::HITS_RST;
        end else begin
            ign_q   <= ign_d;
            brk_q   <= brk_d;
            start_q <= start_d;
            stop_q  <= stop_d;
            hits_q  <= hits_d;
        end
    end

    assign break_o       = brk_q;
    assign hit_chans_o   = hits_q;
    assign count_start_o = start_q;
    assign count_stop_o  = stop_q;

    // =================================================================
    // Checks
    sequence s_restart;
        resume_i;
    endsequence

    sequence s_silent3;
        !break_o [*3];
    endsequence

    a_flash_silent: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $past(flash_busy_i) |-> !break_o && !count_start_o)
        else $error("break raised during flash routine");

    a_flash_halt: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        flash_busy_i |-> !cpu_halt_o && !mem_grant_o)
        else $error("halt or memory access during flash routine");

    a_step_silent: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $past(step_mode_i) |-> !break_o)
        else $error("break raised while stepping");

    a_restart_window: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_restart |=> s_silent3)
        else $error("break raised just after restart");

    a_break_cause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        break_o |-> (hit_chans_o != 8'h00) && $past(bus_valid_i))
        else $error("break without recorded channel");

    a_addr_match: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        break_o && hit_chans_o[7] |-> $past(bus_addr_i) == addr_q[7] || $past(cfg_evt))
        else $error("channel 8 break on foreign address");

    a_upper_nodata: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        den_q[brk_pkg::NCH-1:brk_pkg::DATA_CHANS] == 6'h00)
        else $error("data condition on upper channel");

    a_count_nobrk: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        count_start_o && break_o |-> hit_chans_o[1:0] == 2'h0)
        else $error("counter channel also broke");

endmodule // hardware_break_comparator

// ==== verification/link_emulator.sv ====
// Debug emulator model that offers channel setting commands over the link
`timescale 1ns/1ps
module link_emulator (
    // Link clock and command towards the block
    output logic          link_clk_o,
    output logic          cmd_valid_o,
    output brk_pkg::cmd_t cmd_o,
    // Handshake back from the block
    input  wire logic     cmd_ready_i
);
    // =================================================================
    // Idle state: clock stands still low between commands
    initial begin
        link_clk_o = 1'b0;
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end

    // =================================================================
    // One command; the clock only runs while a transfer is in progress
    task automatic send(input brk_pkg::cmd_t c);
        logic tk;
        int   n;
        n = 0;
        tk = 1'b0;
        cmd_o <= c;
        cmd_valid_o <= 1'b1;
        // 160 ns period keeps the link slower than the 50 ns system clock
        while (!tk && n < 20) begin
            tk = cmd_ready_i;
            #80 link_clk_o = 1'b1;
            n++;
            #1;
            if (tk) begin
                cmd_valid_o <= 1'b0;
                cmd_o <= brk_pkg::cmd_t'(~c); // Released lines show the inverse
            end
            #79 link_clk_o = 1'b0;
        end
        // Keep clocking until the acknowledge has come back
        while (!cmd_ready_i && n < 40) begin
            #80 link_clk_o = 1'b1;
            #80 link_clk_o = 1'b0;
            n++;
        end
    endtask
endmodule // link_emulator

// ==== verification/tb_top.sv ====
// Self-checking bench for the hardware break comparator
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    typedef struct {int due; logic brk; logic [7:0] hits; logic st; logic sp;} note_t;
    // =================================================================
    // Bench state
    logic              clk_i, rst_b_i, link_clk, cmd_valid, cmd_ready;
    logic              bus_valid, bus_write, bus_fetch, flash_busy, step_mode, resume;
    logic              halt_req, mem_req, cpu_halt, mem_grant, brk, cnt_start, cnt_stop;
    logic [23:0]       bus_addr;
    logic [15:0]       bus_data;
    logic [7:0]        hits, ehits;
    logic [31:0]       seed;
    brk_pkg::cmd_t     cmd, cfg [8];
    brk_pkg::action_t  act;
    note_t             q [$], nt;
    int                err_count, n_compared, cyc, rcnt;

    link_emulator u_emu (.link_clk_o(link_clk), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
        .cmd_ready_i(cmd_ready));
    hardware_break_comparator DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_chan_i(cmd.chan),
        .cmd_en_i(cmd.en), .cmd_fetch_i(cmd.fetch), .cmd_data_en_i(cmd.data_en),
        .cmd_dsize_i(cmd.dsize), .cmd_dir_en_i(cmd.dir_en), .cmd_dir_wr_i(cmd.dir_wr),
        .cmd_action_i(cmd.action), .cmd_addr_i(cmd.addr), .cmd_data_i(cmd.data),
        .bus_valid_i(bus_valid), .bus_addr_i(bus_addr), .bus_data_i(bus_data),
        .bus_write_i(bus_write), .bus_fetch_i(bus_fetch), .flash_busy_i(flash_busy),
        .step_mode_i(step_mode), .resume_i(resume), .halt_req_i(halt_req), .mem_req_i(mem_req),
        .cpu_halt_o(cpu_halt), .mem_grant_o(mem_grant), .break_o(brk), .hit_chans_o(hits),
        .count_start_o(cnt_start), .count_stop_o(cnt_stop));

    // =================================================================
    // Helpers: pseudo-random source and per-channel match model
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], ^(seed & 32'h80200003)};
        return seed;
    endfunction

    function automatic logic hit(int i, logic [23:0] a, logic [15:0] d, logic w, logic f);
        brk_pkg::cmd_t c;
        logic [15:0]   m;
        c = cfg[i];
        m = (c.dsize == brk_pkg::SZ_HIGH) ? 16'hFF00 : (c.dsize == brk_pkg::SZ_LOW) ? 16'h00FF : 16'hFFFF;
        return c.en && a == (c.fetch ? {c.addr[23:1], 1'b0} : c.addr) && (!c.fetch || f)
            && (!(c.data_en && i < brk_pkg::DATA_CHANS) || ((d ^ c.data) & m) == 16'h0000)
            && (!c.dir_en || w == c.dir_wr);
    endfunction

    task automatic end_of_test();
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // =================================================================
    // One bus cycle; the expected outcome is queued for the monitor
    task automatic step(input logic idle);
        logic [31:0] r;
        logic [23:0] a;
        logic [15:0] d;
        logic [7:0]  hv;
        logic        v, fl, st, rs, sup, cm;
        note_t       n;
        @(posedge clk_i);
        r = rnd();
        a = cfg[r[2:0]].addr ^ {23'h0, r[3]};
        d = cfg[r[2:0]].data ^ {7'h0, r[4], 7'h0, r[5]};
        v = ~idle & (r[8] | r[9]);
        fl = ~idle & (r[31:28] == 4'h0);
        st = ~idle & (r[27:24] == 4'h0);
        rs = ~idle & (r[23:20] == 4'h0);
        {bus_valid, bus_addr, bus_data, bus_write, bus_fetch} <= {v, a, d, r[6], r[7]};
        {flash_busy, step_mode, resume, halt_req, mem_req} <= {fl, st, rs, r[10], r[11]};
        for (int i = 0; i < 8; i++) hv[i] = v && hit(i, a, d, r[6], r[7]);
        sup = fl | st | rs | (rcnt != 0);
        rcnt = rs ? 2 : (rcnt != 0 ? rcnt - 1 : 0);
        cm = (act == brk_pkg::ACT_CNT_1TO2) || (act == brk_pkg::ACT_CNT_2TO1);
        n.st = cm & ~sup & ((act == brk_pkg::ACT_CNT_1TO2) ? hv[0] : hv[1]);
        n.sp = cm & ~sup & ((act == brk_pkg::ACT_CNT_1TO2) ? hv[1] : hv[0]);
        if (cm) hv[1:0] = 2'b00;
        if (sup) hv = 8'h00;
        if (hv != 8'h00) ehits = hv;
        n.brk = |hv;
        n.hits = ehits;
        n.due = cyc + 1;
        q.push_back(n);
    endtask

    // =================================================================
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // =================================================================
    // Monitor: takes the oldest note when its result is due
    always @(negedge clk_i) begin
        if (q.size() != 0 && q[0].due == cyc) begin
            nt = q.pop_front();
            `CHK("break", nt.brk, brk);
            `CHK("hits", nt.hits, hits);
            `CHK("start", nt.st, cnt_start);
            `CHK("stop", nt.sp, cnt_stop);
        end
        `CHK("halt", halt_req & ~flash_busy, cpu_halt);
        `CHK("grant", mem_req & ~flash_busy, mem_grant);
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            err_count++;
            end_of_test();
        end
    end

    // =================================================================
    // Main sequence: random channel settings, then random bus traffic
    initial begin
        brk_pkg::cmd_t c;
        logic [63:0]   r2;
        {rst_b_i, bus_valid, bus_addr, bus_data, bus_write, bus_fetch} = '0;
        {flash_busy, step_mode, resume, halt_req, mem_req} = '0;
        {err_count, n_compared, cyc, rcnt} = '0;
        seed = 32'hBB15B31B;
        ehits = brk_pkg::HITS_RST;
        act = brk_pkg::ACT_BREAK;
        for (int i = 0; i < 8; i++) cfg[i] = '0;
        repeat (20) @(posedge clk_i);
        `CHK("ready", 1'b1, cmd_ready);
        `CHK("hits", brk_pkg::HITS_RST, hits);
        rst_b_i <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            step(1'b1);
            for (int i = 0; i < 8; i++) begin
                r2 = {rnd(), rnd()};
                c = brk_pkg::cmd_t'(r2[51:0]);
                c.chan = 3'(i);
                c.en = r2[60] | r2[61];
                // Channels 1 and 2 never share an address; the rest may collide
                c.addr = (i < 2) ? 24'h000200 + 24'(16 * i) : 24'h000100 + {21'h0, r2[63:62], 1'b0};
                c.addr[0] = r2[59];
                u_emu.send(c);
                `CHK("ready", 1'b1, cmd_ready);
                cfg[i] = c;
                if (i == 0) act = c.action;
            end
            rcnt = 0;
            repeat (300) step(1'b0);
        end
        step(1'b1);
        repeat (4) @(posedge clk_i);
        // A note never taken means a result went unchecked
        `CHK("notes left", 0, q.size());
        end_of_test();
    end
endmodule // tb_top
